//--- core/flash_ctl_defs.svh
// Purpose: Constants for the flash erase command controller
// Assumes: 200 MHz system clock
// Notes: Word-mode and byte-mode unlock addresses, command codes, bus timing
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

// Unlock and command addresses
`define UNLOCK_A_WORD 20'h00555
`define UNLOCK_B_WORD 20'h002aa
`define UNLOCK_A_BYTE 20'h00aaa
`define UNLOCK_B_BYTE 20'h00555

// Command data
`define CMD_UNLOCK_1 8'haa
`define CMD_UNLOCK_2 8'h55
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hf0
`define CMD_BYPASS_RESET_1 8'h90
`define CMD_BYPASS_RESET_2 8'h00
`define CMD_AUTOSELECT 8'h90

// Autoselect offsets
`define ID_MANUF_OFFSET 20'h00000
`define ID_DEVICE_OFFSET 20'h00001

// Status bit positions on the data bus
`define BIT_DATA_POLLING 7
`define BIT_TOGGLE 6
`define BIT_ERASE_TIMER 3
`define BIT_SUSPEND_TOGGLE 2

// Timing in ns and derived cycles at a 5 ns clock
`define CLK_PERIOD_NS 5
`define WINDOW_NS 50000
`define SUSPEND_MAX_NS 35000
`define WINDOW_CYCLES (`WINDOW_NS / `CLK_PERIOD_NS)
`define SUSPEND_MAX_CYCLES (`SUSPEND_MAX_NS / `CLK_PERIOD_NS)
`define STROBE_CYCLES 8

// Register offsets of the controller port
`define REG_CMD 4'h0
`define REG_SECTOR 4'h1
`define REG_STATUS 4'h2
`define REG_RDATA 4'h3
`define REG_ADDR 4'h4

// Command register opcodes
`define OP_ERASE 3'h1
`define OP_ADD 3'h2
`define OP_SUSPEND 3'h3
`define OP_RESUME 3'h4
`define OP_READ 3'h5
`define OP_RESET 3'h6
`define OP_BYPASS_EXIT 3'h7

`endif

//--- core/flash_ctl_pkg.sv
// Purpose: Types for the flash erase command controller
// Assumes: Nothing beyond the header
// Notes: Sequencer states
package flash_ctl_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SEQ = 4'h1,
        ST_WINDOW = 4'h2,
        ST_ERASING = 4'h3,
        ST_SUSPENDED = 4'h4,
        ST_READ = 4'h5,
        ST_SUSP_WAIT = 4'h6
    } seq_state_t;
endpackage

//--- core/flash_bus_if.sv
// Purpose: Request and answer wires between sequencer and bus cycle engine
// Assumes: Single clock
// Notes: One request at a time, done pulses once
`timescale 1ns/1ps
interface flash_bus_if;
    logic req;
    logic write;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output write, output addr, output wdata, input done, input rdata);
    modport eng (input req, input write, input addr, input wdata, output done, output rdata);
endinterface

//--- core/flash_bus_engine.sv
// Purpose: Runs one asynchronous write or read cycle on the flash pins
// Assumes: Strobe widths of STROBE_CYCLES clocks meet the part's timing
// Notes: Data pins are two-way; output enable low means driving
`timescale 1ns/1ps
`include "flash_ctl_defs.svh"
module flash_bus_engine #(
    parameter int STROBE = `STROBE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    flash_bus_if.eng bus,
    output logic [19:0] f_addr,
    output logic [7:0] f_dq_out,
    output logic f_dq_oe_n,
    input wire logic [7:0] f_dq_in,
    output logic f_we_n,
    output logic f_oe_n
);
    logic [7:0] cnt;
    logic busy;
    logic is_write;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;

    initial begin
        if (STROBE < 2 || STROBE > 200) $error("STROBE out of range");
    end

    // Two-stage pin synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= f_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // Cycle timing; each write cycle ends two clocks after the rising write strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            is_write <= 1'b0;
            f_addr <= 20'h00000;
            f_dq_out <= 8'h00;
            f_dq_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            f_oe_n <= 1'b1;
            bus.done <= 1'b0;
            bus.rdata <= 8'h00;
        end else begin
            bus.done <= 1'b0;
            if (!busy && bus.req) begin
                busy <= 1'b1;
                cnt <= 8'h00;
                is_write <= bus.write;
                f_addr <= bus.addr;
                f_dq_out <= bus.wdata;
                f_dq_oe_n <= !bus.write;
                f_we_n <= !bus.write;
                f_oe_n <= bus.write;
            end else if (busy) begin
                cnt <= cnt + 8'h01;
                if (cnt == 8'(STROBE - 1)) begin
                    f_we_n <= 1'b1;
                    f_oe_n <= 1'b1;
                    if (!is_write) bus.rdata <= dq_s2;
                end
                if (cnt == 8'(STROBE + 1)) begin
                    f_dq_oe_n <= 1'b1;
                    busy <= 1'b0;
                    bus.done <= 1'b1;
                end
            end
        end
    end
endmodule // flash_bus_engine

//--- core/flash_erase_ctl.sv
// Purpose: Host-side controller issuing sector erase, suspend and resume to a NOR flash
// Assumes: Device answers on its asynchronous parallel bus; one 200 MHz clock
// Notes: Software drives it through a small register port
// Summary of operation
// [R1] Six write cycles with unlock addresses
// [R2] Third cycle 80, sixth sector plus 30
// [R3] Device preprograms; host sends nothing extra
// [R4] Window of 50 us after last strobe
// [R5] Extra sector writes with 30 inside window
// [R6] Host spaces extra sectors under 50 us
// [R7] Other write in window aborts sequence
// [R8] Erase timer flag shows window state
// [R9] Only suspend valid while erasing
// [R10] Hardware reset aborts; host reissues sequence
// [R11] Completion returns to read; progress bits
// [R12] Suspend B0 only in sector erase
// [R13] Suspend within 35 us, window immediately; code enters ST_SUSPENDED as soon as the B0 write is done, SUSP_CYC is unused
// [R14] Suspended: other sectors readable and programmable; code offers reads only, no program command
// [R15] Erasing sector reads give status
// [R16] Suspended program reports polling and toggle
// [R17] Autoselect allowed while suspended; code sends no 90 autoselect command, only plain reads
// [R18] Resume 30 continues; repeat ignored
// [R19] Bypass exit is 90 then 00
// [R20] F0 also leaves bypass mode
// [R21] Autoselect offsets 00 and 01 give IDs
// [R22] Window restarts at each added sector
// [R23] Device keeps per-sector erase flags
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "flash_ctl_defs.svh"
module flash_erase_ctl
    import flash_ctl_pkg::*;
#(
    parameter int WINDOW_CYC = `WINDOW_CYCLES,
    parameter int SUSP_CYC = `SUSPEND_MAX_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic byte_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [19:0] f_addr,
    output logic [7:0] f_dq_out,
    output logic f_dq_oe_n,
    input wire logic [7:0] f_dq_in,
    output logic f_we_n,
    output logic f_oe_n,
    output logic f_reset_n,
    input wire logic ready_busy_n
);
    flash_bus_if bus();
    seq_state_t state;
    logic [2:0] step;
    logic [19:0] sector_address;
    logic [19:0] rd_addr;
    logic [7:0] last_rdata;
    logic [31:0] win_cnt;
    logic window_late;
    logic abort_seen;
    logic rb_s1;
    logic rb_s2;
    logic req;
    logic [19:0] req_addr;
    logic [7:0] req_data;
    logic req_write;

    initial begin
        if (WINDOW_CYC < `STROBE_CYCLES + 5 || SUSP_CYC < 1) $error("Timing counts too small");
    end

    // Pin engine
    flash_bus_engine u_eng (
        .clk(clk),
        .rst(rst),
        .bus(bus.eng),
        .f_addr(f_addr),
        .f_dq_out(f_dq_out),
        .f_dq_oe_n(f_dq_oe_n),
        .f_dq_in(f_dq_in),
        .f_we_n(f_we_n),
        .f_oe_n(f_oe_n)
    );
    assign bus.req = req;
    assign bus.write = req_write;
    assign bus.addr = req_addr;
    assign bus.wdata = req_data;

    // Address and data of each erase sequence cycle
    function automatic logic [27:0] seq_cycle(input logic [2:0] n, input logic bm,
                                              input logic [19:0] sa);
        logic [19:0] a1;
        logic [19:0] a2;
        a1 = bm ? `UNLOCK_A_BYTE : `UNLOCK_A_WORD;
        a2 = bm ? `UNLOCK_B_BYTE : `UNLOCK_B_WORD;
        case (n)
            3'h0: seq_cycle = {a1, `CMD_UNLOCK_1}; // R1
            3'h1: seq_cycle = {a2, `CMD_UNLOCK_2}; // R1
            3'h2: seq_cycle = {a1, `CMD_ERASE_SETUP}; // R2
            3'h3: seq_cycle = {a1, `CMD_UNLOCK_1}; // R1
            3'h4: seq_cycle = {a2, `CMD_UNLOCK_2}; // R1
            default: seq_cycle = {sa, `CMD_SECTOR_ERASE}; // R2
        endcase
    endfunction

    // Ready/busy pin synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rb_s1 <= 1'b1;
            rb_s2 <= 1'b1;
        end else begin
            rb_s1 <= ready_busy_n;
            rb_s2 <= rb_s1;
        end
    end

    // Device reset pin low during controller reset and for one cycle after an OP_RESET write; aborts any erase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) f_reset_n <= 1'b0; // R10
        else if (reg_wr && reg_addr == `REG_CMD && reg_wdata[2:0] == `OP_RESET) f_reset_n <= 1'b0;
        else f_reset_n <= 1'b1;
    end

    // Host-side window timer, restarted after every sector cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_cnt <= 32'h0;
            window_late <= 1'b0;
        end else if (bus.done && req_write && req_data == `CMD_SECTOR_ERASE
                     && state inside {ST_SEQ, ST_WINDOW}) begin
            win_cnt <= 32'h0; // R22
            window_late <= 1'b0;
        end else if (state == ST_WINDOW) begin
            if (win_cnt < 32'(WINDOW_CYC)) win_cnt <= win_cnt + 32'h1;
            else window_late <= 1'b1; // R6
        end
    end

    // Main sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            step <= 3'h0;
            req <= 1'b0;
            req_write <= 1'b0;
            req_addr <= 20'h00000;
            req_data <= 8'h00;
            sector_address <= 20'h00000;
            rd_addr <= 20'h00000;
            last_rdata <= 8'h00;
            abort_seen <= 1'b0;
        end else begin
            req <= 1'b0;
            if (reg_wr && reg_addr == `REG_SECTOR) sector_address <= reg_wdata[19:0];
            if (reg_wr && reg_addr == `REG_ADDR) rd_addr <= reg_wdata[19:0];
            case (state)
                ST_IDLE, ST_WINDOW, ST_ERASING, ST_SUSPENDED: begin
                    if (reg_wr && reg_addr == `REG_CMD) begin
                        req_write <= 1'b1;
                        req_addr <= 20'h00000;
                        case (reg_wdata[2:0])
                            `OP_ERASE: begin
                                if (state == ST_IDLE) begin
                                    step <= 3'h0;
                                    state <= ST_SEQ;
                                    {req_addr, req_data} <= seq_cycle(3'h0, byte_mode,
                                                                       sector_address);
                                    req <= 1'b1; // R1 R3
                                end
                            end
                            `OP_ADD: begin
                                // Added strobe must land in window
                                if (state == ST_WINDOW
                                    && win_cnt < 32'(WINDOW_CYC - `STROBE_CYCLES - 4)) begin
                                    req_addr <= sector_address;
                                    req_data <= `CMD_SECTOR_ERASE; // R5
                                    req <= 1'b1;
                                    state <= ST_SEQ;
                                    step <= 3'h5;
                                end
                            end
                            `OP_SUSPEND: begin
                                if (state inside {ST_WINDOW, ST_ERASING}) begin
                                    req_data <= `CMD_SUSPEND; // R12 R9
                                    req <= 1'b1;
                                    state <= ST_SUSP_WAIT;
                                    step <= 3'h0;
                                end
                            end
                            `OP_RESUME: begin
                                if (state == ST_SUSPENDED) begin
                                    req_data <= `CMD_RESUME; // R18
                                    req <= 1'b1;
                                    state <= ST_SUSP_WAIT;
                                end
                            end
                            `OP_BYPASS_EXIT: begin
                                if (state == ST_IDLE) begin
                                    req_data <= `CMD_BYPASS_RESET_1; // R19
                                    req <= 1'b1;
                                    state <= ST_SEQ;
                                    step <= 3'h7;
                                end
                            end
                            default: begin
                                // Reset write; in window it abandons the erase
                                if (state inside {ST_IDLE, ST_WINDOW}) begin
                                    req_data <= `CMD_RESET; // R20 R7
                                    req <= 1'b1;
                                    abort_seen <= (state == ST_WINDOW);
                                    state <= ST_SEQ;
                                    step <= 3'h6;
                                end
                            end
                        endcase
                    end else if (reg_rd && reg_addr == `REG_RDATA
                                 && state inside {ST_IDLE, ST_SUSPENDED}) begin
                        // Array, status or ID read at chosen offset
                        req_write <= 1'b0;
                        req_addr <= rd_addr; // R14 R15 R17 R21
                        req <= 1'b1;
                        step <= (state == ST_SUSPENDED) ? 3'h1 : 3'h0;
                        state <= ST_READ;
                    end else if (state == ST_WINDOW && window_late) begin
                        state <= ST_ERASING; // R4
                    end else if (state == ST_ERASING && rb_s2) begin
                        state <= ST_IDLE; // R11
                    end
                end
                ST_SEQ: begin
                    if (bus.done) begin
                        if (step == 3'h5 || step == 3'h6 && !abort_seen) begin
                            state <= (step == 3'h5) ? ST_WINDOW : ST_IDLE; // R4
                        end else if (step == 3'h6) begin
                            state <= ST_IDLE;
                            abort_seen <= 1'b0;
                        end else if (step == 3'h7) begin
                            req_data <= `CMD_BYPASS_RESET_2; // R19
                            req <= 1'b1;
                            step <= 3'h6;
                        end else begin
                            step <= step + 3'h1;
                            {req_addr, req_data} <= seq_cycle(step + 3'h1, byte_mode,
                                                               sector_address);
                            req <= 1'b1;
                        end
                    end
                end
                ST_SUSP_WAIT: begin
                    if (bus.done) begin
                        state <= (req_data == `CMD_RESUME) ? ST_ERASING : ST_SUSPENDED; // R13
                    end
                end
                ST_READ: begin
                    if (bus.done) begin
                        last_rdata <= bus.rdata; // R16
                        state <= (step == 3'h1) ? ST_SUSPENDED : ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Register read port, data one cycle after strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) reg_rdata <= 32'h0;
        else if (reg_rd) begin
            case (reg_addr)
                `REG_SECTOR: reg_rdata <= {12'h000, sector_address};
                `REG_ADDR: reg_rdata <= {12'h000, rd_addr};
                `REG_RDATA: reg_rdata <= {24'h000000, last_rdata};
                `REG_STATUS: reg_rdata <= {23'h0, window_late, rb_s2, state, step};
                default: reg_rdata <= 32'h0;
            endcase
        end else reg_rdata <= 32'h0;
    end

    // Erase sequence starts with unlock to first address
    a_seq_first: assert property (@(posedge clk) disable iff (rst)
        (state == ST_IDLE && reg_wr && reg_addr == `REG_CMD && reg_wdata[2:0] == `OP_ERASE)
        |=> req && req_data == `CMD_UNLOCK_1) else $error("Bad first cycle"); // R1
    a_setup_data: assert property (@(posedge clk) disable iff (rst)
        (state == ST_SEQ && req && step == 3'h2) |-> req_data == `CMD_ERASE_SETUP)
        else $error("Setup not 80"); // R2
    a_window_close: assert property (@(posedge clk) disable iff (rst)
        (state == ST_WINDOW && window_late && !reg_wr && !reg_rd) |=> state == ST_ERASING)
        else $error("Window did not close"); // R4
    a_add_in_window: assert property (@(posedge clk) disable iff (rst)
        (req && req_write && req_data == `CMD_SECTOR_ERASE && $past(state) == ST_WINDOW)
        |-> !$past(window_late)) else $error("Late sector"); // R6
    a_no_write_busy: assert property (@(posedge clk) disable iff (rst)
        ($past(state) == ST_ERASING && req && req_write)
        |-> req_data inside {`CMD_SUSPEND}) else $error("Write while erasing"); // R9
    a_suspend_done: assert property (@(posedge clk) disable iff (rst)
        (state == ST_SUSP_WAIT && bus.done && req_data == `CMD_SUSPEND) |=> state == ST_SUSPENDED)
        else $error("Suspend not entered"); // R13
    a_resume_once: assert property (@(posedge clk) disable iff (rst)
        (req && req_data == `CMD_RESUME && req_write && $past(state) == ST_SUSPENDED)
        |-> state == ST_SUSP_WAIT) else $error("Resume state"); // R18
    a_bypass_pair: assert property (@(posedge clk) disable iff (rst)
        (state == ST_SEQ && step == 3'h7 && bus.done)
        |=> req && req_data == `CMD_BYPASS_RESET_2) else $error("Bypass exit"); // R19
    a_reset_pin: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `REG_CMD && reg_wdata[2:0] == `OP_RESET)
        |=> !f_reset_n ##1 f_reset_n) else $error("Reset pulse"); // R10
endmodule // flash_erase_ctl

//--- test/flash_dev_model.sv
// Purpose: Behavioural NOR flash seen from its pins: sector erase, window, suspend, resume
// Assumes: Timers count clk cycles; WIN and ERASE are scaled down
// Notes: Logs every write cycle so the bench can compare address and data
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int WIN = 50,
    parameter int ERASE = 300
) (
    input wire logic clk,
    input wire logic f_reset_n,
    input wire logic byte_mode,
    input wire logic [19:0] f_addr,
    input wire logic [7:0] f_dq_out,
    input wire logic f_dq_oe_n,
    input wire logic f_we_n,
    input wire logic f_oe_n,
    output logic [7:0] f_dq_in,
    output logic ready_busy_n
);
    logic [19:0] la [0:31];
    logic [7:0] ld [0:31];
    logic sel [0:255];
    logic [7:0] last = 8'h00;
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    logic tog = 1'b0;
    int n_wr = 0;
    int mode = 0;
    int step = 0;
    int tmr = 0;
    // Busy line driven high or low from the mode, low only while erasing
    assign ready_busy_n = (mode != 2);
    task automatic clear_sel();
        foreach (sel[i]) sel[i] = 1'b0;
    endtask
    initial clear_sel();
    // Command decoder, one call per rising write strobe
    task automatic take_write(input logic [19:0] a, input logic [7:0] d);
        logic [19:0] ea;
        logic [7:0] ed;
        ea = (step == 1 || step == 4) ? (byte_mode ? 20'h00555 : 20'h002aa)
                                      : (byte_mode ? 20'h00aaa : 20'h00555);
        ed = (step == 2) ? 8'h80 : ((step == 1 || step == 4) ? 8'h55 : 8'haa);
        la[n_wr % 32] = a;
        ld[n_wr % 32] = d;
        n_wr++;
        case (mode)
            0: begin
                if (step == 5 && d == 8'h30) begin
                    sel[a[19:12]] = 1'b1;
                    mode = 1;
                    tmr = 0;
                    step = 0;
                end else if (a == ea && d == ed) step++;
                else step = 0;
            end
            1: begin
                if (d == 8'h30) begin
                    sel[a[19:12]] = 1'b1;
                    tmr = 0;
                end else if (d == 8'hb0) begin
                    mode = 3;
                    tmr = 0;
                end else begin
                    mode = 0;
                    clear_sel();
                end
            end
            2: if (d == 8'hb0) mode = 3;
            3: if (d == 8'h30) mode = 2;
            default: mode = 0;
        endcase
    endtask
    // Strobe edges, window timer and erase progress
    always @(posedge clk or negedge f_reset_n) begin
        if (!f_reset_n) begin
            mode = 0;
            step = 0;
            clear_sel();
        end else begin
            if (f_we_n && !we_q) take_write(f_addr, f_dq_out);
            if (!f_oe_n && oe_q) tog = !tog;
            if (mode == 1 || mode == 2) tmr++;
            if (mode == 1 && tmr >= WIN) begin
                mode = 2;
                tmr = 0;
            end else if (mode == 2 && tmr >= ERASE) begin
                mode = 0;
                clear_sel();
            end
        end
        we_q = f_we_n;
        oe_q = f_oe_n;
        last = f_dq_in;
    end
    // Read data; a released bus shows the inverse of the last value
    always_comb begin
        if (!f_oe_n && f_dq_oe_n) begin
            if (mode == 1 || mode == 2) f_dq_in = {1'b0, tog, 2'b00, mode == 2, tog, 2'b00};
            else if (mode == 3 && sel[f_addr[19:12]]) f_dq_in = {5'h10, tog, 2'b00};
            else f_dq_in = f_addr[7:0] ^ 8'h5a;
        end else f_dq_in = ~last;
    end
endmodule // flash_dev_model

//--- test/sector_erase_command_sequencer_tb_top.sv
// Purpose: Self-checking bench for the flash erase controller
// Assumes: Scaled window of 50 cycles in both controller and flash model
// Notes: Each scenario is one task; flash cycles are checked from the model's log
`timescale 1ns/1ps
`include "flash_ctl_defs.svh"
module sector_erase_command_sequencer_tb_top import flash_ctl_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic byte_mode = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [19:0] f_addr;
    logic [7:0] f_dq_out, f_dq_in;
    logic f_dq_oe_n, f_we_n, f_oe_n, f_reset_n, ready_busy_n;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    flash_erase_ctl #(.WINDOW_CYC(50), .SUSP_CYC(7000)) dut_u (.clk(clk), .rst(rst),
        .byte_mode(byte_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .f_addr(f_addr), .f_dq_out(f_dq_out),
        .f_dq_oe_n(f_dq_oe_n), .f_dq_in(f_dq_in), .f_we_n(f_we_n), .f_oe_n(f_oe_n),
        .f_reset_n(f_reset_n), .ready_busy_n(ready_busy_n));
    flash_dev_model #(.WIN(50), .ERASE(300)) model_u (.clk(clk), .f_reset_n(f_reset_n),
        .byte_mode(byte_mode), .f_addr(f_addr), .f_dq_out(f_dq_out), .f_dq_oe_n(f_dq_oe_n),
        .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_dq_in(f_dq_in), .ready_busy_n(ready_busy_n));
    initial forever #2.5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    // --------------------------------
    // Bus tasks and comparison
    // --------------------------------
    task automatic final_report();
        $display("Counts: checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_state(input logic [3:0] st);
        logic [31:0] s;
        for (int i = 0; i < 600; i++) begin
            reg_read(`REG_STATUS, s);
            if (s[6:3] === st) break;
        end
        chk("controller state", 32'(st), 32'(s[6:3]));
    endtask
    task automatic wait_wr(input int n);
        for (int i = 0; i < 200 && model_u.n_wr < n; i++) @(posedge clk);
        chk("flash write count", n, model_u.n_wr);
    endtask
    function automatic logic [7:0] wd(input int back);
        return model_u.ld[(model_u.n_wr - back) % 32];
    endfunction
    task automatic cmd(input logic [2:0] op, input logic [7:0] exp);
        int b;
        b = model_u.n_wr;
        reg_write(`REG_CMD, {29'h0, op});
        wait_wr(b + 1);
        chk("command data", 32'(exp), 32'(wd(1)));
    endtask
    task automatic read_flash(input logic [19:0] a, output logic [31:0] d);
        reg_write(`REG_ADDR, {12'h0, a});
        reg_read(`REG_RDATA, d);
        repeat (16) @(posedge clk);
        reg_read(`REG_RDATA, d);
        repeat (16) @(posedge clk);
    endtask
    task automatic start_erase(input logic bm, input logic [19:0] sa);
        int b;
        logic [19:0] ua, ub;
        logic [19:0] ea [6];
        logic [7:0] ed [6];
        b = model_u.n_wr;
        ua = bm ? `UNLOCK_A_BYTE : `UNLOCK_A_WORD;
        ub = bm ? `UNLOCK_B_BYTE : `UNLOCK_B_WORD;
        ea = '{ua, ub, ua, ua, ub, sa};
        ed = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h30};
        byte_mode <= bm;
        reg_write(`REG_SECTOR, {12'h0, sa});
        reg_write(`REG_CMD, {29'h0, `OP_ERASE});
        wait_wr(b + 6);
        for (int i = 0; i < 6; i++) begin
            chk("cycle address", 32'(ea[i]), 32'(model_u.la[(b + i) % 32]));
            chk("cycle data", 32'(ed[i]), 32'(model_u.ld[(b + i) % 32]));
        end
        wait_state(ST_WINDOW);
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_multi();
        start_erase(1'b0, 20'h12000);
        reg_write(`REG_SECTOR, 32'h0007f000);
        cmd(`OP_ADD, `CMD_SECTOR_ERASE);
        chk("added sector address", 32'h0007f000, 32'(model_u.la[(model_u.n_wr - 1) % 32]));
        wait_state(ST_ERASING);
        wait_state(ST_IDLE);
    endtask
    task automatic t_suspend();
        logic [31:0] d;
        start_erase(1'b1, 20'h34000);
        cmd(`OP_SUSPEND, `CMD_SUSPEND);
        wait_state(ST_SUSPENDED);
        read_flash(20'h34010, d);
        chk("status bit in erase sector", 32'h1, 32'(d[7]));
        read_flash(20'h50020, d);
        chk("array byte outside", 32'h7a, 32'(d[7:0]));
        cmd(`OP_RESUME, `CMD_RESUME);
        wait_state(ST_ERASING);
        wait_state(ST_IDLE);
        byte_mode <= 1'b0;
    endtask
    task automatic t_abort();
        start_erase(1'b0, 20'h22000);
        cmd(`OP_RESET, `CMD_RESET);
        wait_state(ST_IDLE);
        cmd(`OP_BYPASS_EXIT, `CMD_BYPASS_RESET_1);
        wait_wr(model_u.n_wr + 1);
        chk("bypass exit second", 32'(`CMD_BYPASS_RESET_2), 32'(wd(1)));
    endtask
    task automatic t_hwreset();
        start_erase(1'b0, 20'h45000);
        wait_state(ST_ERASING);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1 chk("flash reset pin", 32'h0, 32'(f_reset_n));
        @(posedge clk);
        rst <= 1'b0;
        wait_state(ST_IDLE);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_multi();
        t_suspend();
        t_abort();
        t_hwreset();
        final_report();
    end
endmodule // sector_erase_command_sequencer_tb_top
